//--- rtl/pa_pkg.sv
// How it works
// RL1: Upstream sends legal vertex counts per topology; others are undefined.
// RL2: Vertices are buffered and an object leaves once enough have arrived.
// RL3: Points use 1 vertex, lines 2, triangles and boxes 3.
// RL4: Each valid object slot carries X, Y, Z, 1/W and attribute handle.
// RL5: Winding flip flag tells setup to invert triangle orientation.
// RL6: Rear side flag marks point and line objects as back facing.
// RL7: Area pattern enable is set except for the unpatterned hub topology.
// RL8: Line pattern resume says whether stippling continues from last line.
// RL9: Target layer index passes through untouched from the leading vertex.
// RL10: Point diameter is forwarded for points as the square size.
// RL11: Each point takes its viewport select from its own vertex.
// RL12: Independent lines take viewport select from their leading vertex.
// RL13: Chained segments take viewport select from their leading vertex.
// RL14: Triangle and box lists take viewport select from leading vertex.
// RL15: Chained triangles take viewport select from their leading vertex.
// RL16: Hub and convex area objects all take the first vertex's select.
// RL17: Shared vertices are resent with every object so each maps again.
// RL18: Point lists emit one point per vertex in order, flat index 0.
// RL19: Rear point variant sets rear side flag, plain variant clears it.
// RL20: Independent lines pair 0-1, 2-3 with programmed index, no resume.
// RL21: Chained segments pair 0-1, 1-2 with the programmed line index.
// RL22: Rear chain variants set rear flag; resume variants resume first line.
// RL23: Every segment after the first in a chain forces resume true.
package pa_pkg;
  localparam int POS_W = 32;
  localparam int HDL_W = 16;
  localparam int LAYER_W = 11;
  localparam int VP_W = 4;
  localparam int DIAM_W = 16;
  localparam int X_LSB = 0;
  localparam int Y_LSB = X_LSB + POS_W;
  localparam int Z_LSB = Y_LSB + POS_W;
  localparam int W_LSB = Z_LSB + POS_W;
  localparam int HDL_LSB = W_LSB + POS_W;
  localparam int LAYER_LSB = HDL_LSB + HDL_W;
  localparam int VP_LSB = LAYER_LSB + LAYER_W;
  localparam int DIAM_LSB = VP_LSB + VP_W;
  localparam int VTX_W = DIAM_LSB + DIAM_W;

  localparam logic [3:0] TOPO_TRI_INDEPENDENT = 4'h1;
  localparam logic [3:0] TOPO_TRI_CHAIN = 4'h2;
  localparam logic [3:0] TOPO_TRI_CHAIN_FLIPPED = 4'h3;
  localparam logic [3:0] TOPO_TRI_HUB = 4'h4;
  localparam logic [3:0] TOPO_TRI_HUB_UNPATTERNED = 4'h5;
  localparam logic [3:0] TOPO_CONVEX_AREA = 4'h6;
  localparam logic [3:0] TOPO_SEG_INDEPENDENT = 4'h7;
  localparam logic [3:0] TOPO_SEG_CHAIN = 4'h8;
  localparam logic [3:0] TOPO_SEG_CHAIN_RESUME = 4'h9;
  localparam logic [3:0] TOPO_SEG_CHAIN_REAR = 4'hA;
  localparam logic [3:0] TOPO_SEG_CHAIN_RESUME_REAR = 4'hB;
  localparam logic [3:0] TOPO_BOX_INDEPENDENT = 4'hC;
  localparam logic [3:0] TOPO_DOT_INDEPENDENT = 4'hD;
  localparam logic [3:0] TOPO_DOT_INDEPENDENT_REAR = 4'hE;
  localparam logic [3:0] TOPO_DOT_REAR_ALIAS = 4'hE;

  localparam logic [1:0] SHAPE_DOT = 2'h0;
  localparam logic [1:0] SHAPE_SEGMENT = 2'h1;
  localparam logic [1:0] SHAPE_TRI = 2'h2;
  localparam logic [1:0] SHAPE_BOX = 2'h3;

  localparam logic [1:0] VPO_DOT = 2'h1;
  localparam logic [1:0] VPO_SEG = 2'h2;
  localparam logic [1:0] VPO_TRI = 2'h3;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 12'h004;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int CFG_LINE_PV_LSB = 0;
  localparam int CFG_TRI_PV_LSB = 2;
  localparam int CFG_HUB_PV_LSB = 4;
  localparam int CFG_W = 6;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_CNT_W = 16;
  localparam int STAT_PEND_BIT = 16;
endpackage

//--- rtl/pa_vslot.sv
`timescale 1ns/1ps
`default_nettype none
// One stored vertex, loaded as a whole on ld
module pa_vslot #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ld,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ld) begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/pa_assembly.sv
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pa_assembly (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pa_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vin_valid,
  output logic vin_ready,
  input wire logic [3:0] vin_topology_code,
  input wire logic vin_prim_start,
  input wire logic [pa_pkg::POS_W-1:0] vin_x,
  input wire logic [pa_pkg::POS_W-1:0] vin_y,
  input wire logic [pa_pkg::POS_W-1:0] vin_z,
  input wire logic [pa_pkg::POS_W-1:0] vin_inv_w,
  input wire logic [pa_pkg::HDL_W-1:0] vin_attr_handle,
  input wire logic [pa_pkg::LAYER_W-1:0] vin_target_layer_index,
  input wire logic [pa_pkg::VP_W-1:0] vin_transform_select_index,
  input wire logic [pa_pkg::DIAM_W-1:0] vin_point_diameter,
  output logic obj_valid,
  input wire logic obj_ready,
  output logic [1:0] obj_shape_class,
  output logic [1:0] obj_vertex_per_object_count,
  output logic [2:0][pa_pkg::POS_W-1:0] obj_x,
  output logic [2:0][pa_pkg::POS_W-1:0] obj_y,
  output logic [2:0][pa_pkg::POS_W-1:0] obj_z,
  output logic [2:0][pa_pkg::POS_W-1:0] obj_inv_w,
  output logic [2:0][pa_pkg::HDL_W-1:0] obj_attr_handle,
  output logic obj_winding_flip_flag,
  output logic obj_rear_side,
  output logic [1:0] obj_flat_shade_vertex_index,
  output logic obj_area_pattern_enable,
  output logic obj_line_pattern_resume,
  output logic [pa_pkg::LAYER_W-1:0] obj_target_layer_index,
  output logic [pa_pkg::VP_W-1:0] obj_viewport_select,
  output logic [pa_pkg::DIAM_W-1:0] obj_point_diameter
);
  import pa_pkg::*;

  // Register file state
  logic [CFG_W-1:0] cfg_r;
  logic [STAT_CNT_W-1:0] obj_cnt_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // Vertex sequencing state
  logic [1:0] n_r;
  logic [1:0] ph_r;
  logic par_r;
  logic vin_ready_r;
  logic obj_valid_r;

  // Object attribute registers
  logic [1:0] shape_r;
  logic [1:0] vpo_r;
  logic flip_r;
  logic rear_r;
  logic [1:0] pv_r;
  logic area_r;
  logic resume_r;

  // APB decode
  wire apb_first = psel & penable & ~pready_r;
  wire apb_done = psel & penable & pready_r;
  // Full offset compare; anything else is an unmapped access
  wire hit_cfg = (paddr == CFG_OFFSET);
  wire hit_stat = (paddr == STAT_OFFSET);
  wire hit_any = hit_cfg | hit_stat;
  wire cfg_we = apb_done & pwrite & hit_cfg;
  wire [1:0] line_pv = cfg_r[CFG_LINE_PV_LSB +: 2];
  wire [1:0] tri_pv = cfg_r[CFG_TRI_PV_LSB +: 2];
  wire [1:0] hub_pv = cfg_r[CFG_HUB_PV_LSB +: 2];


  // Read views of the two registers
  logic [31:0] cfg_word;
  logic [31:0] stat_word;
  always_comb begin
    cfg_word = '0;
    cfg_word[CFG_W-1:0] = cfg_r;
    stat_word = '0;
    stat_word[STAT_CNT_LSB +: STAT_CNT_W] = obj_cnt_r;
    stat_word[STAT_PEND_BIT] = obj_valid_r;
  end
  wire [31:0] rd_word = hit_cfg ? cfg_word : (hit_stat ? stat_word : '0);

  // Topology decode
  wire [3:0] topo = vin_topology_code;
  wire is_dot = (topo == TOPO_DOT_INDEPENDENT) |
                (topo == TOPO_DOT_INDEPENDENT_REAR) |
                (topo == TOPO_DOT_REAR_ALIAS);
  wire dot_rear = (topo == TOPO_DOT_INDEPENDENT_REAR) |
                  (topo == TOPO_DOT_REAR_ALIAS);
  wire is_seg_list = (topo == TOPO_SEG_INDEPENDENT);
  wire seg_resume = (topo == TOPO_SEG_CHAIN_RESUME) |
                    (topo == TOPO_SEG_CHAIN_RESUME_REAR);
  wire seg_rear = (topo == TOPO_SEG_CHAIN_REAR) |
                  (topo == TOPO_SEG_CHAIN_RESUME_REAR);
  wire is_seg_chain = (topo == TOPO_SEG_CHAIN) | seg_resume | seg_rear;
  wire is_tri_list = (topo == TOPO_TRI_INDEPENDENT);
  wire is_box = (topo == TOPO_BOX_INDEPENDENT);
  wire chain_flipped = (topo == TOPO_TRI_CHAIN_FLIPPED);
  wire is_tri_chain = (topo == TOPO_TRI_CHAIN) | chain_flipped;
  wire hub_plain = (topo == TOPO_TRI_HUB);
  wire is_convex = (topo == TOPO_CONVEX_AREA);
  wire hub_unpat = (topo == TOPO_TRI_HUB_UNPATTERNED);
  wire is_hub = hub_plain | hub_unpat | is_convex;
  // Shape groups that share the same slot selection
  wire is_seg = is_seg_list | is_seg_chain;
  wire is_tri3 = is_tri_list | is_box | is_tri_chain;

  // Position of the arriving vertex within its topology
  wire acc = vin_valid & vin_ready_r;
  wire [1:0] n_cur = vin_prim_start ? 2'd0 : n_r;
  wire [1:0] ph_cur = vin_prim_start ? 2'd0 : ph_r;
  wire par_cur = vin_prim_start ? 1'b0 : par_r;
  // Saturates at 3: chains only ask whether one or two vertices are held
  wire [1:0] n_inc = (n_cur == 2'd3) ? 2'd3 : n_cur + 2'd1;

  // Vertices needed per object, which gives the list emit phase
  wire [1:0] vpo = is_dot ? VPO_DOT : (is_seg ? VPO_SEG : VPO_TRI); // RL3
  wire list_emit = (ph_cur == vpo - 2'd1);
  wire emit_dot = is_dot; // RL18
  wire emit_seg_list = is_seg_list & list_emit; // RL20
  wire emit_seg_chain = is_seg_chain & (n_cur != 2'd0); // RL21
  wire emit_tri_list = (is_tri_list | is_box) & list_emit;
  wire emit_chain3 = (is_tri_chain | is_hub) & (n_cur >= 2'd2);
  wire emit_kind = emit_dot | emit_seg_list | emit_seg_chain |
                   emit_tri_list | emit_chain3;
  // An object leaves only with a vertex that was really taken
  wire emit = acc & emit_kind; // RL2
  // List phase wraps after the last vertex of each object
  wire [1:0] ph_nxt = list_emit ? 2'd0 : ph_cur + 2'd1;

  // Vertex history and object vertex slots
  logic [VTX_W-1:0] slot_d [6];
  logic [VTX_W-1:0] slot_q [6];
  logic slot_ld [6];
  // One slot word carries a whole vertex, X in the low bits
  wire [VTX_W-1:0] vin_vtx = {vin_point_diameter,
                              vin_transform_select_index,
                              vin_target_layer_index,
                              vin_attr_handle,
                              vin_inv_w,
                              vin_z,
                              vin_y,
                              vin_x};

  // Slot 0 keeps the hub vertex, slots 1 and 2 the last two arrivals
  wire [VTX_W-1:0] hub_q = slot_q[0];
  wire [VTX_W-1:0] p1_q = slot_q[1];
  wire [VTX_W-1:0] p2_q = slot_q[2];

  // Leading vertex first; every object gets its own copy of shared vertices
  wire [VTX_W-1:0] obj_a = is_hub ? hub_q : // RL16
                           is_tri3 ? p2_q : // RL14 RL15
                           is_seg ? p1_q : vin_vtx; // RL11 RL12 RL13
  wire [VTX_W-1:0] obj_b = (is_hub | is_tri3) ? p1_q :
                           is_seg ? vin_vtx : '0;
  wire [VTX_W-1:0] obj_c = (is_hub | is_tri3) ? vin_vtx : '0;

  // Slots 3 to 5 capture the object as setup will see it
  always_comb begin
    slot_d[0] = vin_vtx;
    slot_ld[0] = acc & (n_cur == 2'd0);
    slot_d[1] = vin_vtx;
    slot_ld[1] = acc;
    slot_d[2] = p1_q;
    slot_ld[2] = acc;
    slot_d[3] = obj_a;
    slot_d[4] = obj_b;
    slot_d[5] = obj_c;
    slot_ld[3] = emit; // RL17
    slot_ld[4] = emit;
    slot_ld[5] = emit;
  end

  // One register per stored vertex word
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_slot
      pa_vslot #(.W(VTX_W)) u_slot (
        .pclk(pclk),
        .presetn(presetn),
        .ld(slot_ld[gi]),
        .d(slot_d[gi]),
        .q(slot_q[gi])
      );
    end
    for (gi = 0; gi < 3; gi++) begin : g_out
      assign obj_x[gi] = slot_q[3+gi][X_LSB +: POS_W]; // RL4
      assign obj_y[gi] = slot_q[3+gi][Y_LSB +: POS_W];
      assign obj_z[gi] = slot_q[3+gi][Z_LSB +: POS_W];
      assign obj_inv_w[gi] = slot_q[3+gi][W_LSB +: POS_W];
      assign obj_attr_handle[gi] = slot_q[3+gi][HDL_LSB +: HDL_W];
    end
  endgenerate

  // Per-object fields follow the leading vertex in slot 3
  assign obj_target_layer_index = slot_q[3][LAYER_LSB +: LAYER_W]; // RL9
  assign obj_viewport_select = slot_q[3][VP_LSB +: VP_W];
  assign obj_point_diameter = slot_q[3][DIAM_LSB +: DIAM_W]; // RL10

  // Per-object flags
  logic [1:0] shape_nxt;
  logic flip_nxt;
  logic rear_nxt;
  logic [1:0] pv_nxt;
  logic area_nxt;
  logic resume_nxt;
  always_comb begin
    shape_nxt = SHAPE_TRI;
    flip_nxt = 1'b0;
    rear_nxt = 1'b0;
    pv_nxt = 2'd0;
    area_nxt = 1'b1;
    resume_nxt = 1'b0;
    if (is_dot) begin
      shape_nxt = SHAPE_DOT;
      rear_nxt = dot_rear; // RL19 RL6
      pv_nxt = 2'd0; // RL18
    end else if (is_seg_list) begin
      shape_nxt = SHAPE_SEGMENT;
      pv_nxt = line_pv; // RL20
      resume_nxt = 1'b0; // RL8
    end else if (is_seg_chain) begin
      shape_nxt = SHAPE_SEGMENT;
      pv_nxt = line_pv; // RL21
      rear_nxt = seg_rear; // RL22
      resume_nxt = (n_cur == 2'd1) ? seg_resume : 1'b1; // RL22 RL23
    end else if (is_box) begin
      shape_nxt = SHAPE_BOX;
    end else if (is_tri_list) begin
      pv_nxt = tri_pv;
    end else if (is_tri_chain) begin
      pv_nxt = tri_pv;
      flip_nxt = chain_flipped ^ par_cur; // RL5
    end else if (is_hub) begin
      pv_nxt = is_convex ? 2'd0 : hub_pv;
      area_nxt = ~hub_unpat; // RL7
    end
  end

  // Handshake: a new vertex is taken only while no object is pending
  wire obj_valid_nxt = emit | (obj_valid_r & ~obj_ready);

  // Parity counts chain triangles so the winding alternates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_r <= 2'd0;
      ph_r <= 2'd0;
      par_r <= 1'b0;
    end else if (acc) begin
      n_r <= n_inc;
      ph_r <= ph_nxt;
      par_r <= par_cur ^ emit_chain3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obj_valid_r <= 1'b0;
      vin_ready_r <= 1'b1;
    end else begin
      obj_valid_r <= obj_valid_nxt;
      vin_ready_r <= ~obj_valid_nxt; // RL2
    end
  end

  // Flags are captured together with the object slots on emit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shape_r <= SHAPE_DOT;
      vpo_r <= VPO_DOT;
      flip_r <= 1'b0;
      rear_r <= 1'b0;
      pv_r <= 2'd0;
      area_r <= 1'b0;
      resume_r <= 1'b0;
    end else if (emit) begin
      shape_r <= shape_nxt;
      vpo_r <= vpo; // RL3
      flip_r <= flip_nxt;
      rear_r <= rear_nxt;
      pv_r <= pv_nxt;
      area_r <= area_nxt;
      resume_r <= resume_nxt;
    end
  end

  // APB slave: one wait state, error on unmapped offsets
  // pslverr rides with pready and leaves the registers alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apb_first;
      pslverr_r <= apb_first & ~hit_any;
      if (apb_first) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // Writes to the status word are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RESET[CFG_W-1:0];
    end else if (cfg_we) begin
      cfg_r <= pwdata[CFG_W-1:0];
    end
  end

  // Counts emits and wraps; pending objects are counted already
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obj_cnt_r <= '0;
    end else if (emit) begin
      obj_cnt_r <= obj_cnt_r + 16'h0001;
    end
  end

  // Outputs are plain copies of registers
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign vin_ready = vin_ready_r;
  assign obj_valid = obj_valid_r;
  assign obj_shape_class = shape_r;
  assign obj_vertex_per_object_count = vpo_r;
  assign obj_winding_flip_flag = flip_r;
  assign obj_rear_side = rear_r;
  assign obj_flat_shade_vertex_index = pv_r;
  assign obj_area_pattern_enable = area_r;
  assign obj_line_pattern_resume = resume_r;
endmodule
`default_nettype wire

//--- dv/pa_assembly_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pa_assembly_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic vin_valid,
  input wire logic vin_ready,
  input wire logic [3:0] vin_topology_code,
  input wire logic [pa_pkg::POS_W-1:0] vin_x,
  input wire logic [pa_pkg::VP_W-1:0] vin_transform_select_index,
  input wire logic obj_valid,
  input wire logic obj_ready,
  input wire logic [1:0] obj_shape_class,
  input wire logic [1:0] obj_vertex_per_object_count,
  input wire logic [2:0][pa_pkg::POS_W-1:0] obj_x,
  input wire logic obj_rear_side,
  input wire logic [1:0] obj_flat_shade_vertex_index,
  input wire logic obj_area_pattern_enable,
  input wire logic [pa_pkg::VP_W-1:0] obj_viewport_select
);
  import pa_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic take = vin_valid && vin_ready;
  wire logic is_dot = vin_topology_code == TOPO_DOT_INDEPENDENT ||
    vin_topology_code == TOPO_DOT_INDEPENDENT_REAR;
  sequence s_take_dot;
    take && is_dot;
  endsequence
  sequence s_unpat_obj;
    take && vin_topology_code == TOPO_TRI_HUB_UNPATTERNED ##1 obj_valid;
  endsequence
  property p_hold;
    obj_valid && !obj_ready |=> obj_valid && $stable(obj_x);
  endproperty
  a_hold: assert property (p_hold) else $error("object moved in stall");
  property p_stall;
    obj_valid |-> !vin_ready;
  endproperty
  a_stall: assert property (p_stall) else $error("vertex taken early");
  property p_done;
    obj_valid && obj_ready |=> !obj_valid;
  endproperty
  a_done: assert property (p_done) else $error("object repeated");
  property p_dot_cnt;
    obj_valid && obj_shape_class == SHAPE_DOT |->
      obj_vertex_per_object_count == 2'd1 && obj_flat_shade_vertex_index == 0;
  endproperty
  a_dot_cnt: assert property (p_dot_cnt) else $error("dot count");
  property p_seg_cnt;
    obj_valid && obj_shape_class == SHAPE_SEGMENT |->
      obj_vertex_per_object_count == 2'd2 && obj_x[2] == '0;
  endproperty
  a_seg_cnt: assert property (p_seg_cnt) else $error("seg count");
  property p_dot_emit;
    s_take_dot |=> obj_valid && obj_shape_class == SHAPE_DOT &&
      obj_x[0] == $past(vin_x) &&
      obj_viewport_select == $past(vin_transform_select_index);
  endproperty
  a_dot_emit: assert property (p_dot_emit) else $error("dot emit");
  property p_dot_rear;
    s_take_dot |=> obj_rear_side ==
      ($past(vin_topology_code) == TOPO_DOT_INDEPENDENT_REAR);
  endproperty
  a_dot_rear: assert property (p_dot_rear) else $error("dot rear");
  property p_unpat;
    s_unpat_obj |-> !obj_area_pattern_enable;
  endproperty
  a_unpat: assert property (p_unpat) else $error("area enable");
endmodule
bind pa_assembly pa_assembly_chk u_chk (
  .pclk, .presetn, .vin_valid, .vin_ready, .vin_topology_code, .vin_x,
  .vin_transform_select_index, .obj_valid, .obj_ready, .obj_shape_class,
  .obj_vertex_per_object_count, .obj_x, .obj_rear_side,
  .obj_flat_shade_vertex_index, .obj_area_pattern_enable,
  .obj_viewport_select
);
`default_nettype wire

//--- dv/pa_obj_sink.sv
`timescale 1ns/1ps
`default_nettype none
// Object setup side: takes every object at once, or stalls at random
module pa_obj_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  output logic obj_ready
);
  logic [15:0] lfsr_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= 16'hace1;
      obj_ready <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[14:0],
                 lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      obj_ready <= !slow || lfsr_r[1:0] == 2'b00;
    end
  end
endmodule
`default_nettype wire

//--- dv/pa_assembly_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pa_assembly_bench;
  import pa_pkg::*;
  typedef struct {
    logic [POS_W-1:0] x;
    logic [VP_W-1:0] vp;
    logic [LAYER_W-1:0] ly;
    logic [DIAM_W-1:0] dm;
    logic [POS_W-1:0] y, z, w;
    logic [HDL_W-1:0] h;
  } pa_vtx_t;
  typedef struct {
    logic [1:0] sh, cnt, fl;
    pa_vtx_t v[3];
    logic wf, rear, ar, rs;
    pa_vtx_t lead;
  } pa_obj_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, slow = 1'b0, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic vin_valid = 1'b0, vin_prim_start = 1'b0, vin_ready;
  logic [3:0] vin_topology_code = '0;
  logic [POS_W-1:0] vin_x = '0, vin_y = '0, vin_z = '0, vin_inv_w = '0;
  logic [HDL_W-1:0] vin_attr_handle = '0;
  logic [LAYER_W-1:0] vin_target_layer_index = '0, obj_target_layer_index;
  logic [VP_W-1:0] vin_transform_select_index = '0, obj_viewport_select;
  logic [DIAM_W-1:0] vin_point_diameter = '0, obj_point_diameter;
  logic obj_valid, obj_ready, obj_winding_flip_flag, obj_rear_side;
  logic obj_area_pattern_enable, obj_line_pattern_resume;
  logic [1:0] obj_shape_class, obj_vertex_per_object_count;
  logic [1:0] obj_flat_shade_vertex_index;
  logic [2:0][POS_W-1:0] obj_x, obj_y, obj_z, obj_inv_w;
  logic [2:0][HDL_W-1:0] obj_attr_handle;
  int n_errors = 0;
  int total_checks = 0;
  int nobj = 0;
  logic [31:0] seed = 32'h0000_6743;
  logic [5:0] cfg = '0;
  pa_vtx_t hist[$];
  pa_obj_t expq[$];
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  pa_assembly u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .vin_valid, .vin_ready, .vin_topology_code,
    .vin_prim_start, .vin_x, .vin_y, .vin_z, .vin_inv_w, .vin_attr_handle,
    .vin_target_layer_index, .vin_transform_select_index,
    .vin_point_diameter, .obj_valid, .obj_ready, .obj_shape_class,
    .obj_vertex_per_object_count, .obj_x, .obj_y, .obj_z, .obj_inv_w,
    .obj_attr_handle, .obj_winding_flip_flag, .obj_rear_side,
    .obj_flat_shade_vertex_index, .obj_area_pattern_enable,
    .obj_line_pattern_resume, .obj_target_layer_index,
    .obj_viewport_select, .obj_point_diameter
  );
  pa_obj_sink u_sink (.pclk, .presetn, .slow, .obj_ready);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (s !== 1'b1 && n < 64);
    if (s !== 1'b1) begin
      chk("wait", 32'h1, 32'h0);
      complete_run();
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Works out the object that vertex i of the topology completes, if any
  function automatic void expect_obj(input logic [3:0] c);
    pa_obj_t o;
    int i, k, s0;
    bit dot, seg, hub, lst;
    i = hist.size() - 1;
    dot = c inside {TOPO_DOT_INDEPENDENT, TOPO_DOT_INDEPENDENT_REAR};
    seg = c inside {[TOPO_SEG_INDEPENDENT:TOPO_SEG_CHAIN_RESUME_REAR]};
    hub = c inside {[TOPO_TRI_HUB:TOPO_CONVEX_AREA]};
    lst = c inside {TOPO_SEG_INDEPENDENT, TOPO_TRI_INDEPENDENT,
                    TOPO_BOX_INDEPENDENT};
    k = dot ? 1 : (seg ? 2 : 3);
    if (lst ? (i % k != k - 1) : (i < k - 1))
      return;
    s0 = i - k + 1;
    o = '{default: '0};
    o.sh = dot ? SHAPE_DOT : seg ? SHAPE_SEGMENT :
      c == TOPO_BOX_INDEPENDENT ? SHAPE_BOX : SHAPE_TRI;
    o.cnt = 2'(k);
    for (int j = 0; j < k; j++)
      o.v[j] = hist[s0 + j];
    if (hub)
      o.v[0] = hist[0];
    o.lead = hist[hub ? 0 : s0];
    o.wf = (c == TOPO_TRI_CHAIN_FLIPPED) ^
      (c inside {TOPO_TRI_CHAIN, TOPO_TRI_CHAIN_FLIPPED} && s0 % 2 == 1);
    o.rear = c inside {TOPO_DOT_INDEPENDENT_REAR, TOPO_SEG_CHAIN_REAR,
                       TOPO_SEG_CHAIN_RESUME_REAR};
    o.rs = seg && c != TOPO_SEG_INDEPENDENT && (s0 > 0 ||
      c inside {TOPO_SEG_CHAIN_RESUME, TOPO_SEG_CHAIN_RESUME_REAR});
    o.ar = c != TOPO_TRI_HUB_UNPATTERNED;
    o.fl = seg ? cfg[1:0] :
      c inside {TOPO_TRI_HUB, TOPO_TRI_HUB_UNPATTERNED} ? cfg[5:4] :
      c inside {[TOPO_TRI_INDEPENDENT:TOPO_TRI_CHAIN_FLIPPED]} ? cfg[3:2] : 0;
    expq.push_back(o);
  endfunction
  task automatic send(input logic [3:0] c, input bit st);
    pa_vtx_t v;
    v.x = xs();
    v.y = xs();
    v.z = xs();
    v.w = xs();
    v.h = HDL_W'(xs());
    v.vp = VP_W'(xs());
    v.ly = LAYER_W'(xs());
    v.dm = DIAM_W'(xs());
    if (st)
      hist.delete();
    vin_valid <= 1'b1;
    vin_topology_code <= c;
    vin_prim_start <= st;
    vin_x <= v.x;
    vin_y <= v.y;
    vin_z <= v.z;
    vin_inv_w <= v.w;
    vin_attr_handle <= v.h;
    vin_target_layer_index <= v.ly;
    vin_transform_select_index <= v.vp;
    vin_point_diameter <= v.dm;
    hist.push_back(v);
    wait_hi(vin_ready);
    expect_obj(c);
  endtask
  always @(posedge pclk) begin
    pa_obj_t e;
    if (obj_valid === 1'b1 && obj_ready === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : '{default: '1};
      nobj++;
      chk("shape", e.sh, obj_shape_class);
      chk("count", e.cnt, obj_vertex_per_object_count);
      for (int j = 0; j < 3; j++) begin
        chk("slot x", e.v[j].x, obj_x[j]);
        chk("slot y", e.v[j].y, obj_y[j]);
        chk("slot z", e.v[j].z, obj_z[j]);
        chk("slot w", e.v[j].w, obj_inv_w[j]);
        chk("slot h", e.v[j].h, obj_attr_handle[j]);
      end
      chk("vp", e.lead.vp, obj_viewport_select);
      chk("layer", e.lead.ly, obj_target_layer_index);
      chk("flat", e.fl, obj_flat_shade_vertex_index);
      if (e.sh == SHAPE_DOT)
        chk("diam", e.lead.dm, obj_point_diameter);
      if (e.sh == SHAPE_TRI)
        chk("wind", e.wf, obj_winding_flip_flag);
      if (e.sh == SHAPE_TRI)
        chk("area", e.ar, obj_area_pattern_enable);
      if (e.sh == SHAPE_DOT || e.sh == SHAPE_SEGMENT)
        chk("rear", e.rear, obj_rear_side);
      if (e.sh == SHAPE_SEGMENT)
        chk("resume", e.rs, obj_line_pattern_resume);
    end
  end
  initial begin
    int k, n;
    bit lst;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk("cfg reset", CFG_RESET, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    for (int r = 0; r < 2; r++) begin
      slow <= (r == 1);
      cfg = 6'(xs());
      apb(1'b1, CFG_OFFSET, {26'h0, cfg});
      apb(1'b0, CFG_OFFSET, 32'h0);
      chk("cfg", {26'h0, cfg}, rd);
      chk("cfg err", 32'h0, {31'h0, err});
      for (int c = 1; c <= 14; c++) begin
        k = c >= 13 ? 1 : (c >= 7 && c <= 11) ? 2 : 3;
        lst = c == 1 || c == 7 || c == 12;
        n = r == 0 ? k : lst ? k * (2 + xs() % 2) : k + 1 + xs() % 4;
        for (int i = 0; i < n; i++)
          send(4'(c), i == 0);
        vin_valid <= 1'b0;
        n = 0;
        while (expq.size() != 0 && n < 64) begin
          @(posedge pclk);
          n++;
        end
        chk("drained", 32'h0, expq.size());
      end
    end
    apb(1'b1, STAT_OFFSET, 32'hffff_ffff);
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk("stat", {16'h0, 16'(nobj)}, rd);
    complete_run();
  end
endmodule
`default_nettype wire
